//--- common/rd_map.vh
`ifndef RD_MAP_VH
`define RD_MAP_VH
// ==========================================================
// sizes
`define RD_NUM_PTS 16
`define RD_NUM_EQ 17
`define RD_LOCKOUT_PT 5'h10
`define RD_GROUP_LIMIT 3'h6
`define RD_GROUP_RST 3'h0
`define RD_TXT_WORDS 128
`define RD_TXT_SLOTS 32
`define RD_EQ_SLOTS 256
// ==========================================================
// rotation timing
`define RD_ROT_TIME_MS 2000
`define RD_CLK_KHZ 100000
`define RD_ROT_CYCLES (`RD_ROT_TIME_MS * `RD_CLK_KHZ)
// ==========================================================
// equation control word fields and modes
`define RD_CTL_MODE 1:0
`define RD_CTL_INV 2
`define RD_CTL_W 3
`define RD_MODE_C0 2'h0
`define RD_MODE_C1 2'h1
`define RD_MODE_ANY 2'h2
`define RD_MODE_ALL 2'h3
`define RD_CTL_RST 3'h0
`define RD_MASK_RST 32'h00000000
`define RD_LEN_RST 5'h00
`define RD_LEN_W 5
`define RD_LEN_MAX 5'h10
// ==========================================================
// address map, byte addresses on a 14-bit window
`define RD_AW 14
`define RD_RGN 13:12
`define RD_RGN_CSR 2'h0
`define RD_RGN_EQ 2'h1
`define RD_RGN_TXT 2'h2
`define RD_RGN_LEN 2'h3
`define RD_OFF_GROUP 14'h0000
`define RD_OFF_STATUS 14'h0004
`define RD_OFF_VISIBLE 14'h0008
`define RD_EQ_GRP 10:8
`define RD_EQ_PT 7:3
`define RD_EQ_SEL 2
`define RD_EQ_PAD 11
`define RD_TXT_IDX 8:2
`define RD_TXT_PAD 11:9
`define RD_LEN_IDX 6:2
`define RD_LEN_PAD 11:7
// ==========================================================
// status register fields
`define RD_ST_STATES 15:0
`define RD_ST_LOCK 16
`define RD_ST_PT 23:20
`define RD_ST_VALID 24
// ==========================================================
// bus answers and misc
`define RD_RESP_OKAY 2'h0
`define RD_RESP_SLVERR 2'h2
`define RD_ZERO32 32'h00000000
`define RD_ONE32 32'h00000001
`define RD_PT_RST 4'hF
`define RD_SG_ONE 6'h01
`endif

//--- rtl/rd_eq_eval.v
`include "rd_map.vh"
`default_nettype none
// ==========================================================
// one logic equation: constant, or OR / AND over masked bits
module rd_eq_eval (
  input wire [31:0] relay_word,
  input wire [31:0] mask,
  input wire [`RD_CTL_W-1:0] ctl,
  output reg value
);
  wire [31:0] hit = relay_word & mask;
  wire any_w = |hit;
  // an empty mask under AND reads as true, like an empty product
  wire all_w = ((hit ^ mask) == `RD_ZERO32);

  // constants ignore the inversion bit so they stay permanent
  always @* begin
    case (ctl[`RD_CTL_MODE])
      `RD_MODE_C0: value = 1'b0;
      `RD_MODE_C1: value = 1'b1;
      `RD_MODE_ANY: value = any_w ^ ctl[`RD_CTL_INV];
      `RD_MODE_ALL: value = all_w ^ ctl[`RD_CTL_INV];
      default: value = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/rd_rotate_top.v
// Operation
// - a point whose equation is one shows its true text, zero its false text.
// - a blank selected text means that point shows nothing in the rotation.
// - only one of the two texts may be set, giving a screen in one state only.
// - a constant equation shows its non-blank text in every rotation pass.
// - every setting group holds its own equation for each of the 16 points.
// - both texts of a point are stored once and shared by all groups.
// - after a group switch the new group's equations choose the screens.
// - a constant-one lockout equation keeps reclosing off whatever the input.
// - the display moves on to the next shown point every two seconds.
// - an equation may combine any relay word bits, inputs and group flags.
`include "rd_map.vh"
`default_nettype none
module rd_rotate_top #(
  parameter [31:0] ROT_CYCLES = `RD_ROT_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [`RD_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`RD_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire breaker_status_input,
  input wire reclose_enable_input,
  input wire [23:0] relay_bits,
  output reg disp_valid_r,
  output reg [3:0] disp_point_r,
  output reg disp_state_r,
  output reg [`RD_LEN_W-1:0] disp_len_r,
  output reg [127:0] disp_text_r,
  output reg reclose_lockout_r
);
  // ==========================================================
  // storage: equations per group, texts shared by all groups
  reg [31:0] eq_mask [0:`RD_EQ_SLOTS-1];
  reg [`RD_CTL_W-1:0] eq_ctl [0:`RD_EQ_SLOTS-1];
  reg [31:0] txt_mem [0:`RD_TXT_WORDS-1];
  reg [`RD_LEN_W-1:0] txt_len [0:`RD_TXT_SLOTS-1];
  reg [2:0] group_r;
  reg [`RD_NUM_PTS-1:0] state_r;
  reg [`RD_NUM_PTS-1:0] vis_r;
  reg [3:0] cur_r;
  reg [31:0] rot_cnt_r;
  reg [`RD_AW-1:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg aw_full_r;
  reg w_full_r;
  integer i;

  // ==========================================================
  // relay word: loose bits, group indicators, the two inputs
  wire [5:0] sg_ind = `RD_SG_ONE << group_r;
  wire [31:0] relay_word = {relay_bits, sg_ind, reclose_enable_input,
                            breaker_status_input};
  wire [`RD_NUM_EQ-1:0] eq_val;
  wire [`RD_NUM_PTS-1:0] vis_w;

  genvar gi;
  generate
    for (gi = 0; gi < `RD_NUM_EQ; gi = gi + 1) begin : g_eq
      localparam [4:0] PI = gi;
      // the active group picks which equation set is evaluated
      wire [7:0] slot = {group_r, PI};
      rd_eq_eval u_eval (
        .relay_word(relay_word),
        .mask(eq_mask[slot]),
        .ctl(eq_ctl[slot]),
        .value(eq_val[gi])
      );
      if (gi < `RD_NUM_PTS) begin : g_vis
        // shared text chosen by state; zero length means blank
        wire [4:0] ti = {PI[3:0], state_r[gi]};
        assign vis_w[gi] = (txt_len[ti] != `RD_LEN_RST);
      end
    end
  endgenerate

  // ==========================================================
  // two-second step enable from a free-running divider
  wire tick = (rot_cnt_r == ROT_CYCLES - `RD_ONE32);

  always @(posedge aclk) begin
    if (!aresetn) begin
      rot_cnt_r <= `RD_ZERO32;
    end else if (tick) begin
      rot_cnt_r <= `RD_ZERO32;
    end else begin
      rot_cnt_r <= rot_cnt_r + `RD_ONE32;
    end
  end

  // search the next shown point above the current one, wrapping
  reg [3:0] next_pt;
  reg next_found;
  reg [3:0] cand;
  integer k;
  always @* begin
    next_pt = cur_r;
    next_found = 1'b0;
    cand = cur_r;
    for (k = 1; k <= `RD_NUM_PTS; k = k + 1) begin
      cand = cur_r + k[3:0];
      if (!next_found && vis_r[cand]) begin
        next_found = 1'b1;
        next_pt = cand;
      end
    end
  end

  // ==========================================================
  // states, rotation and display registers
  wire [4:0] cur_ti = {cur_r, state_r[cur_r]};
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= {`RD_NUM_PTS{1'b0}};
      vis_r <= {`RD_NUM_PTS{1'b0}};
      cur_r <= `RD_PT_RST;
      reclose_lockout_r <= 1'b0;
      disp_valid_r <= 1'b0;
      disp_point_r <= `RD_PT_RST;
      disp_state_r <= 1'b0;
      disp_len_r <= `RD_LEN_RST;
      disp_text_r <= {4{`RD_ZERO32}};
    end else begin
      state_r <= eq_val[`RD_NUM_PTS-1:0];
      vis_r <= vis_w;
      // constant one locks out even with the enable input high
      reclose_lockout_r <= eq_val[`RD_LOCKOUT_PT];
      if (tick) begin
        cur_r <= next_pt;
      end
      // the screen follows the current state between steps too,
      // so a group switch shows at once rather than at the next step
      disp_point_r <= cur_r;
      disp_state_r <= state_r[cur_r];
      disp_valid_r <= vis_r[cur_r];
      disp_len_r <= txt_len[cur_ti];
      disp_text_r <= {txt_mem[{cur_ti, 2'h3}], txt_mem[{cur_ti, 2'h2}],
                      txt_mem[{cur_ti, 2'h1}], txt_mem[{cur_ti, 2'h0}]};
    end
  end

  // ==========================================================
  // address decode shared by the read and write paths
  function map_ok;
    input [`RD_AW-1:0] a;
    begin
      case (a[`RD_RGN])
        `RD_RGN_CSR: map_ok = (a == `RD_OFF_GROUP) ||
                              (a == `RD_OFF_STATUS) ||
                              (a == `RD_OFF_VISIBLE);
        `RD_RGN_EQ: map_ok = !a[`RD_EQ_PAD] &&
                             (a[`RD_EQ_GRP] < `RD_GROUP_LIMIT) &&
                             (a[`RD_EQ_PT] <= `RD_LOCKOUT_PT) &&
                             (a[1:0] == 2'h0);
        `RD_RGN_TXT: map_ok = (a[`RD_TXT_PAD] == 3'h0) &&
                              (a[1:0] == 2'h0);
        `RD_RGN_LEN: map_ok = (a[`RD_LEN_PAD] == 5'h00) &&
                              (a[1:0] == 2'h0);
        default: map_ok = 1'b0;
      endcase
    end
  endfunction

  // byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================================
  // write channel: address and data taken in either order
  wire do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  wire [7:0] wr_slot = {aw_addr_r[`RD_EQ_GRP], aw_addr_r[`RD_EQ_PT]};
  wire [6:0] wr_txt = aw_addr_r[`RD_TXT_IDX];
  wire [4:0] wr_len = aw_addr_r[`RD_LEN_IDX];
  wire [31:0] wr_mrg_mask = merge(eq_mask[wr_slot], w_data_r, w_strb_r);
  wire [31:0] wr_mrg_ctl = merge({29'h0, eq_ctl[wr_slot]}, w_data_r,
                                 w_strb_r);
  wire [31:0] wr_mrg_txt = merge(txt_mem[wr_txt], w_data_r, w_strb_r);
  wire [31:0] wr_mrg_len = merge({27'h0, txt_len[wr_len]}, w_data_r,
                                 w_strb_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RD_RESP_OKAY;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= `RD_OFF_GROUP;
      w_data_r <= `RD_ZERO32;
      w_strb_r <= 4'h0;
      group_r <= `RD_GROUP_RST;
      for (i = 0; i < `RD_EQ_SLOTS; i = i + 1) begin
        eq_mask[i] <= `RD_MASK_RST;
        eq_ctl[i] <= `RD_CTL_RST;
      end
      for (i = 0; i < `RD_TXT_SLOTS; i = i + 1) begin
        txt_len[i] <= `RD_LEN_RST;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= map_ok(aw_addr_r) ? `RD_RESP_OKAY : `RD_RESP_SLVERR;
        if (map_ok(aw_addr_r)) begin
          case (aw_addr_r[`RD_RGN])
            // out-of-range group numbers are dropped silently
            `RD_RGN_CSR: if (aw_addr_r == `RD_OFF_GROUP && w_strb_r[0] &&
                             w_data_r[2:0] < `RD_GROUP_LIMIT) begin
              group_r <= w_data_r[2:0];
            end
            `RD_RGN_EQ: if (aw_addr_r[`RD_EQ_SEL]) begin
              eq_ctl[wr_slot] <= wr_mrg_ctl[`RD_CTL_W-1:0];
            end else begin
              eq_mask[wr_slot] <= wr_mrg_mask;
            end
            `RD_RGN_TXT: txt_mem[wr_txt] <= wr_mrg_txt;
            `RD_RGN_LEN: begin
              // lengths above the screen width are clipped
              if (wr_mrg_len[`RD_LEN_W-1:0] > `RD_LEN_MAX) begin
                txt_len[wr_len] <= `RD_LEN_MAX;
              end else begin
                txt_len[wr_len] <= wr_mrg_len[`RD_LEN_W-1:0];
              end
            end
            default: group_r <= group_r;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // read channel: one access at a time, data one cycle later
  reg [31:0] rd_nxt;
  wire [7:0] rd_slot = {s_axi_araddr[`RD_EQ_GRP], s_axi_araddr[`RD_EQ_PT]};
  always @* begin
    rd_nxt = `RD_ZERO32;
    case (s_axi_araddr[`RD_RGN])
      `RD_RGN_CSR: begin
        if (s_axi_araddr == `RD_OFF_GROUP) begin
          rd_nxt[2:0] = group_r;
        end else if (s_axi_araddr == `RD_OFF_STATUS) begin
          rd_nxt[`RD_ST_STATES] = state_r;
          rd_nxt[`RD_ST_LOCK] = reclose_lockout_r;
          rd_nxt[`RD_ST_PT] = disp_point_r;
          rd_nxt[`RD_ST_VALID] = disp_valid_r;
        end else if (s_axi_araddr == `RD_OFF_VISIBLE) begin
          rd_nxt[`RD_NUM_PTS-1:0] = vis_r;
        end
      end
      `RD_RGN_EQ: begin
        if (s_axi_araddr[`RD_EQ_SEL]) begin
          rd_nxt[`RD_CTL_W-1:0] = eq_ctl[rd_slot];
        end else begin
          rd_nxt = eq_mask[rd_slot];
        end
      end
      `RD_RGN_TXT: rd_nxt = txt_mem[s_axi_araddr[`RD_TXT_IDX]];
      `RD_RGN_LEN: rd_nxt[`RD_LEN_W-1:0] = txt_len[s_axi_araddr[`RD_LEN_IDX]];
      default: rd_nxt = `RD_ZERO32;
    endcase
    if (!map_ok(s_axi_araddr)) begin
      rd_nxt = `RD_ZERO32;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RD_ZERO32;
      s_axi_rresp <= `RD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_nxt;
      s_axi_rresp <= map_ok(s_axi_araddr) ? `RD_RESP_OKAY : `RD_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/rd_rotate_chk.sv
`default_nettype none
// ==========================================================
// bus handshake and rotation dwell checks
module rd_rotate_chk #(
  parameter int ROT_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] disp_point_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a write counts only when both channels go on one edge and no
  // answer is still open, so the answer is not held back
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    !s_axi_bvalid;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence r_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  // the write lands from the holding registers one edge after both
  // halves are taken, and the answer rises on that same edge
  a_b_follows: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_b_release: assert property (b_done |=> !s_axi_bvalid && s_axi_wready)
    else $error("write not closed");
  a_r_follows: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_release: assert property (r_done |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not closed");
  // write readies come back with the answer, the read ready only after it is taken; none right after a take
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready)
    else $error("write address taken twice");
  a_w_busy: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("write data taken twice");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer open");
  a_bresp_code: assert property (s_axi_bvalid |->
    s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  // a screen must stand for eight cycles after a change, not flicker
  a_pt_dwell: assert property ($changed(disp_point_r) |=>
    $stable(disp_point_r)[*8])
    else $error("screen changed too soon");
  // cycles since the shown point last moved; seeded so that the
  // first step after reset also lands on a whole period
  int since_chg;
  wire logic on_period = (since_chg % ROT_CYCLES == 0);
  always @(posedge aclk) begin
    if (!aresetn) begin
      since_chg <= ROT_CYCLES - 1;
    end else if ($changed(disp_point_r)) begin
      since_chg <= 1;
    end else begin
      since_chg <= since_chg + 1;
    end
  end
  // a step may skip blank slots but never falls between two ticks
  a_pt_period: assert property ($changed(disp_point_r) |-> on_period)
    else $error("screen step off the period");
endmodule
`default_nettype wire

//--- tb/rd_panel_model.sv
`default_nettype none
// ==========================================================
// operator view: notes each new screen that appears
module rd_panel_model (
  input wire logic aclk,
  input wire logic disp_valid_r,
  input wire logic [3:0] disp_point_r,
  output var logic [3:0] last_pt,
  output var int n_scr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    last_pt = 4'hF;
    n_scr = 0;
  end
  // a blank slot leaves the panel empty, so it is not counted
  always @(posedge aclk) begin
    if (disp_valid_r && disp_point_r !== last_pt) begin
      last_pt <= disp_point_r;
      n_scr <= n_scr + 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ROT = 20;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, en, brk, dv, ds, lk;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, tw;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] ws, dp, lp, pv;
  logic [23:0] rbits;
  logic [4:0] dl;
  logic [127:0] dt;
  int n_errors, n_compared, seed, n_scr, n, k, i;
  rd_rotate_top #(.ROT_CYCLES(ROT)) u_rd_rotate_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .breaker_status_input(brk),
    .reclose_enable_input(en), .relay_bits(rbits), .disp_valid_r(dv),
    .disp_point_r(dp), .disp_state_r(ds), .disp_len_r(dl),
    .disp_text_r(dt), .reclose_lockout_r(lk));
  rd_panel_model u_rd_panel_model (.aclk(aclk), .disp_valid_r(dv),
    .disp_point_r(dp), .last_pt(lp), .n_scr(n_scr));
  // ==========================================================
  // bus tasks and expectations
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // each valid drops on the edge where its own ready is seen, so each channel closes on its own edge
  task automatic wr(input logic [13:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
    logic pa, pw;
    pa = 1;
    pw = 1;
    awaddr <= a;
    wdata <= d;
    ws <= s;
    awvalid <= 1;
    wvalid <= 1;
    while (pa || pw) begin
      @(posedge aclk);
      if (awready) pa = 0;
      if (wready) pw = 0;
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
  endtask
  task automatic rdr(input logic [13:0] a);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
  endtask
  task automatic eq(input int g, input int p, input logic [31:0] m,
      input logic [31:0] c);
    wr(14'(32'h1000 + g * 256 + p * 8), m);
    wr(14'(32'h1004 + g * 256 + p * 8), c);
  endtask
  function automatic logic [31:0] est(input logic e, input logic b);
    est = {15'h0, !e, 10'h0, 1'b1, 1'b0, e & b, b, e, 1'b0};
  endfunction
  function automatic logic [31:0] evis(input logic b);
    evis = {25'h0, 2'b11, 2'b00, b, 1'b1, 1'b0};
  endfunction
  function automatic logic [31:0] lenf(input logic [3:0] p);
    lenf = (p == 1) ? 10 : (p == 2) ? 14 : (p == 5) ? 11 : 16;
  endfunction
  // next shown point above the current one, wrapping round
  function automatic logic [3:0] nxt(input logic [15:0] v,
      input logic [3:0] c);
    logic [3:0] j;
    nxt = c;
    for (int s = 15; s >= 1; s--) begin
      j = c + s[3:0];
      if (v[j]) nxt = j;
    end
  endfunction
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    seed = 35870;
    {aresetn, awvalid, wvalid, arvalid, en, brk} = 0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, ws, rbits} = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdr(14'h0000);
    chk(rd, 0);
    rdr(14'h000C);
    chk(32'(rs), 2);
    wr(14'h0000, 6);
    chk(32'(rs), 0);
    wr(14'h000C, 1);
    chk(32'(rs), 2);
    wr(14'h0000, 3, 4'hE);
    rdr(14'h0000);
    chk(rd, 0);
    $display("register test done");
    // points 1..3 follow inputs, 5 and 6 constant, lockout is !enable
    eq(0, 1, 2, 2);
    eq(0, 2, 1, 2);
    eq(0, 3, 3, 3);
    eq(0, 5, 0, 1);
    eq(0, 16, 2, 6);
    eq(3, 16, 0, 1);
    eq(3, 7, 32'h20, 2);
    wr(14'h3008, 11);
    wr(14'h300C, 10);
    wr(14'h3014, 14);
    wr(14'h302C, 11);
    wr(14'h3030, 20);
    tw = $random(seed);
    wr(14'h20B0, tw);
    for (i = 0; i < 12; i++) begin
      en <= (i < 2) ? ~i[0] : 1'($random(seed));
      brk <= (i < 2) ? i[0] : 1'($random(seed));
      rbits <= 24'($random(seed));
      repeat (4) @(posedge aclk);
      rdr(14'h0004);
      chk(rd & 32'h1FFFF, est(en, brk));
      chk(32'(lk), 32'(!en));
      rdr(14'h0008);
      chk(rd & 32'hFFFF, evis(brk));
    end
    $display("equation test done");
    en <= 1;
    brk <= 1;
    for (i = 0; i < 7; i++) begin
      n = n_scr;
      k = 0;
      while (n_scr == n && k < 3 * ROT) begin
        @(posedge aclk);
        k++;
      end
      if (i > 0) begin
        chk(32'(lp), 32'(nxt(16'h0066, pv)));
        chk(k, ROT);
        chk(32'(dv), 1);
        chk(32'(ds), 32'(lp != 6));
        chk(32'(dl), lenf(lp));
        if (lp == 5) chk(dt[31:0], tw);
      end
      pv = lp;
    end
    $display("rotation test done");
    wr(14'h0000, 3);
    en <= 0;
    repeat (5) @(posedge aclk);
    chk(32'(lk), 1);
    en <= 1;
    repeat (5) @(posedge aclk);
    chk(32'(lk), 1);
    rdr(14'h0004);
    chk(rd & 32'h82, 32'h80);
    rdr(14'h0008);
    chk(32'(rd[1]), 1);
    wr(14'h0000, 0);
    repeat (5) @(posedge aclk);
    rdr(14'h0004);
    chk(rd & 32'h10082, 32'h2);
    $display("group test done");
    report_and_stop();
  end
endmodule
bind rd_rotate_top rd_rotate_chk #(.ROT_CYCLES(ROT_CYCLES)) u_rd_rotate_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .disp_point_r(disp_point_r));
`default_nettype wire
